//--- src/adc_seq_defs.svh
// Offsets, reset values and timing figures of the converter sequence control.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define OFS_CONTROL_ZERO   8'h00
`define OFS_RESERVED_CTRL  8'h04
`define OFS_POWER_IRQ      8'h08
`define OFS_DEBUG_FREEZE   8'h0c
`define OFS_TIMING         8'h10
`define OFS_START          8'h14
`define OFS_STATUS         8'h18
`define OFS_RESULT_BASE    3'h1
`define RESULT_SEL_MSB     7
`define RESULT_SEL_LSB     5

`define TIMING_RESET       8'h01
`define ZERO_PRESCALE_SUB  5'h01
`define SAMPLE_BASE        6'h02
`define CONV_BASE_8BIT     6'h10
`define CONV_BASE_10BIT    6'h12
`define LAST_OF_FOUR       3'h3
`define LAST_OF_EIGHT      3'h7
`define FREEZE_FINISH      2'h2
`define FREEZE_NOW         2'h3
`define LOW_BITS_8BIT      2

`endif

//--- src/adc_seq_pkg.sv
// Types shared by the converter sequence control.
// Assumes the constants header sits on the include path.
`include "adc_seq_defs.svh"

package adc_seq_pkg;

    typedef struct packed {
        logic       converter_power_up;
        logic       fast_flag_clear;
        logic       wait_mode_stop;
        logic [2:0] unused;
        logic       sequence_irq_enable;
        logic       sequence_irq_flag;
    } power_irq_t;

    typedef struct packed {
        logic       ten_bit_select;
        logic [1:0] sample_time;
        logic [4:0] clock_prescale;
    } timing_t;

    typedef struct packed {
        logic       unused;
        logic       eight_conversion_select;
        logic       scan_select;
        logic       multichannel_select;
        logic [3:0] channel;
    } start_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } seq_state_t;

endpackage

//--- src/adc_sequence_control.sv
// Sequencer, prescaler, flags and APB register file of a 16-channel converter.
// Assumes an APB master on MCLK and an analog core that holds its result on
// ADC_DATA when ADC_LOAD pulses; all inputs are synchronous to MCLK.
//
// Chosen here: register access over APB and the register addresses.
`include "adc_seq_defs.svh"

module adc_sequence_control
    import adc_seq_pkg::*;
#(
    parameter int RESULT_COUNT = 8,
    parameter int DATA_WIDTH   = 10
) (
    input  wire logic                  MCLK,         // Peripheral clock.
    input  wire logic                  RESET,        // Synchronous reset, active high.
    input  wire logic                  PSEL,         // APB select.
    input  wire logic                  PENABLE,      // APB access phase.
    input  wire logic                  PWRITE,       // APB direction.
    input  wire logic [7:0]            PADDR,        // APB byte address.
    input  wire logic [31:0]           PWDATA,       // APB write data.
    output logic      [31:0]           PRDATA,       // APB read data.
    output logic                       PREADY,       // APB ready.
    output logic                       PSLVERR,      // APB error on unmapped address.
    input  wire logic                  SPECIAL_MODE, // Chip runs in special mode.
    input  wire logic                  WAIT_MODE,    // Processor is in wait mode.
    input  wire logic                  DEBUG_ACTIVE, // Background debug is active.
    input  wire logic [DATA_WIDTH-1:0] ADC_DATA,     // Result from the analog core.
    output logic                       ADC_CLK,      // Symmetric converter clock.
    output logic                       ADC_POWER,    // Analog section powered.
    output logic                       ADC_SAMPLE,   // Sample phase in progress.
    output logic                       ADC_LOAD,     // Result taken this cycle.
    output logic                       ADC_TEN_BIT,  // 10-bit resolution selected.
    output logic      [3:0]            ADC_CHANNEL,  // Analog multiplexer select.
    output logic                       IRQ           // Sequence-complete interrupt.
);

    // The result map and the status layout hold exactly eight 10-bit results.
    if (RESULT_COUNT != 8 || DATA_WIDTH != 10) begin : g_bad_params
        $error("Sequencer serves exactly eight 10-bit results.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    logic [7:0]            control_zero_reg, control_zero_next;
    power_irq_t            power_reg,        power_next;
    logic [1:0]            freeze_reg,       freeze_next;
    timing_t               timing_reg,       timing_next;
    start_t                start_reg,        start_next;
    seq_state_t            state_reg,        state_next;
    logic                  seq_flag_reg,     seq_flag_next;
    logic [7:0]            ccf_reg,          ccf_next;
    logic                  stat_read_reg,    stat_read_next;
    logic [2:0]            conv_idx_reg,     conv_idx_next;
    logic [5:0]            period_reg,       period_next;
    logic [4:0]            pre_cnt_reg,      pre_cnt_next;
    logic                  half_reg,         half_next;
    logic [DATA_WIDTH-1:0] result_reg [8];
    logic [DATA_WIDTH-1:0] load_value;

    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic [3:0]  channel_reg, channel_next;
    logic        sample_reg, sample_next;
    logic        load_reg, load_next;
    logic        irq_reg, irq_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Read data is captured at setup; every side effect acts at the access edge.
    logic       setup_phase, access_done, wr, rd, mapped, is_result;
    logic [2:0] res_sel;
    logic [31:0] read_mux;

    always_comb begin
        setup_phase = PSEL && !PENABLE;
        access_done = PSEL && PENABLE && pready_reg;
        is_result   = PADDR[`RESULT_SEL_MSB:`RESULT_SEL_LSB] == `OFS_RESULT_BASE
                      && PADDR[1:0] == 2'h0;
        res_sel     = PADDR[4:2];
        mapped      = is_result
                      || PADDR == `OFS_CONTROL_ZERO || PADDR == `OFS_RESERVED_CTRL
                      || PADDR == `OFS_POWER_IRQ    || PADDR == `OFS_DEBUG_FREEZE
                      || PADDR == `OFS_TIMING       || PADDR == `OFS_START
                      || PADDR == `OFS_STATUS;
        wr          = access_done && PWRITE && mapped;
        rd          = access_done && !PWRITE && mapped;
        read_mux    = 32'h0;
        if (is_result) begin
            read_mux = {{(32 - DATA_WIDTH){1'b0}}, result_reg[res_sel]};
        end else begin
            unique case (PADDR)
                `OFS_CONTROL_ZERO:  read_mux = {24'h0, control_zero_reg};
                `OFS_RESERVED_CTRL: read_mux = 32'h0;
                `OFS_POWER_IRQ:     read_mux = {24'h0, power_reg};
                `OFS_DEBUG_FREEZE:  read_mux = {30'h0, freeze_reg};
                `OFS_TIMING:        read_mux = {24'h0, timing_reg};
                `OFS_START:         read_mux = {24'h0, start_reg};
                `OFS_STATUS:        read_mux = {16'h0, seq_flag_reg, 4'h0,
                                                conv_idx_reg, ccf_reg};
                default:            read_mux = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler and converter clock.

    logic [4:0] divide_by;
    logic       conv_tick;

    always_comb begin
        // Each half period lasts divide_by plus one cycles, keeping the clock symmetric.
        divide_by = (timing_reg.clock_prescale == 5'h0) ? `ZERO_PRESCALE_SUB
                                                         : timing_reg.clock_prescale;
        pre_cnt_next = pre_cnt_reg;
        half_next    = half_reg;
        conv_tick    = 1'b0;
        if (!power_reg.converter_power_up) begin
            pre_cnt_next = 5'h0;
            half_next    = 1'b0;
        end else if (pre_cnt_reg >= divide_by) begin
            pre_cnt_next = 5'h0;
            half_next    = !half_reg;
            conv_tick    = half_reg;
        end else begin
            pre_cnt_next = pre_cnt_reg + 5'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer, flags and registers.

    logic       abort, start, stall, conv_end, last_conv;
    logic [5:0] sample_len, conv_len;
    logic [2:0] last_idx;

    always_comb begin
        control_zero_next = control_zero_reg;
        power_next        = power_reg;
        freeze_next       = freeze_reg;
        timing_next       = timing_reg;
        start_next        = start_reg;
        state_next        = state_reg;
        seq_flag_next     = seq_flag_reg;
        ccf_next          = ccf_reg;
        stat_read_next    = stat_read_reg;
        conv_idx_next     = conv_idx_reg;
        period_next       = period_reg;
        load_next         = 1'b0;

        sample_len = `SAMPLE_BASE << timing_reg.sample_time;
        conv_len   = sample_len + (timing_reg.ten_bit_select ? `CONV_BASE_10BIT
                                                             : `CONV_BASE_8BIT);
        last_idx   = start_reg.eight_conversion_select ? `LAST_OF_EIGHT
                                                       : `LAST_OF_FOUR;
        // Freeze-on-finish stalls only on a conversion boundary, so a started one ends.
        stall      = (power_reg.wait_mode_stop && WAIT_MODE)
                     || (DEBUG_ACTIVE && freeze_reg == `FREEZE_NOW)
                     || (DEBUG_ACTIVE && freeze_reg == `FREEZE_FINISH
                         && period_reg == 6'h0);
        conv_end   = state_reg == ST_RUN && conv_tick && !stall
                     && period_reg == conv_len - 6'h1;
        last_conv  = conv_idx_reg == last_idx;

        // Software accesses to the flags; hardware sets below override them.
        if (rd && PADDR == `OFS_STATUS) begin
            stat_read_next = 1'b1;
        end
        if (access_done && is_result) begin
            if (power_reg.fast_flag_clear) begin
                ccf_next[res_sel] = 1'b0;
                if (!PWRITE) begin
                    seq_flag_next = 1'b0;
                end
            end else if (!PWRITE && stat_read_reg) begin
                ccf_next[res_sel] = 1'b0;
                stat_read_next    = 1'b0;
            end
        end

        // Writes to control zero, power, freeze and timing abort; only a later start write brings the sequencer back.
        abort = wr && (PADDR == `OFS_CONTROL_ZERO || PADDR == `OFS_POWER_IRQ
                       || PADDR == `OFS_DEBUG_FREEZE || PADDR == `OFS_TIMING);
        start = wr && PADDR == `OFS_START;

        if (wr) begin
            unique case (PADDR)
                `OFS_CONTROL_ZERO: control_zero_next = PWDATA[7:0];
                `OFS_POWER_IRQ: begin
                    power_next                   = power_irq_t'(PWDATA[7:0]);
                    power_next.unused            = 3'h0;
                    power_next.sequence_irq_flag = power_reg.sequence_irq_flag;
                end
                `OFS_DEBUG_FREEZE: freeze_next = PWDATA[1:0];
                `OFS_TIMING:       timing_next = timing_t'(PWDATA[7:0]);
                `OFS_START: begin
                    start_next        = start_t'(PWDATA[7:0]);
                    start_next.unused = 1'b0;
                end
                default: ;
            endcase
        end

        // A start write wins over an abort and over a completion in the same cycle.
        if (start) begin
            seq_flag_next = 1'b0;
            ccf_next      = 8'h0;
            conv_idx_next = 3'h0;
            period_next   = 6'h0;
            state_next    = power_reg.converter_power_up ? ST_RUN : ST_IDLE;
        end else if (abort) begin
            conv_idx_next = 3'h0;
            period_next   = 6'h0;
            state_next    = ST_IDLE;
        end else if (state_reg == ST_RUN && conv_tick && !stall) begin
            if (conv_end) begin
                load_next         = 1'b1;
                ccf_next[conv_idx_reg] = 1'b1;
                period_next       = 6'h0;
                conv_idx_next     = conv_idx_reg + 3'h1;
                if (last_conv) begin
                    seq_flag_next = 1'b1;
                    conv_idx_next = 3'h0;
                    state_next    = start_reg.scan_select ? ST_RUN : ST_IDLE;
                end
            end else begin
                period_next = period_reg + 6'h1;
            end
        end

        // Power-down overrides every other transition so the core never runs unclocked.
        if (!power_next.converter_power_up) begin
            state_next = ST_IDLE;
            if (!start) begin
                conv_idx_next = 3'h0;
                period_next   = 6'h0;
            end
        end
        power_next.sequence_irq_flag = seq_flag_next;

        // The select follows the next index, so it matches the conversion in progress.
        channel_next = start_next.channel;
        if (start_next.multichannel_select) begin
            channel_next = start_next.eight_conversion_select
                           ? {start_next.channel[3], conv_idx_next}
                           : {start_next.channel[3:2], conv_idx_next[1:0]};
        end
        // Sampling covers the first sample_len converter periods of each conversion.
        sample_next = state_next == ST_RUN && period_next < sample_len;
        irq_next    = power_next.sequence_irq_enable && seq_flag_next;

        // Every transfer gets exactly one access cycle and never a wait state.
        pready_next  = setup_phase;
        pslverr_next = setup_phase && !mapped;
        prdata_next  = prdata_reg;
        if (setup_phase) begin
            prdata_next = PWRITE ? 32'h0 : read_mux;
            if (PADDR == `OFS_RESERVED_CTRL && SPECIAL_MODE) begin
                prdata_next = {24'h0, control_zero_reg};
            end
        end
    end

    // In 8-bit mode the two lowest result bits are stored as zero.
    always_comb begin
        load_value = ADC_DATA;
        if (!timing_reg.ten_bit_select) begin
            load_value[`LOW_BITS_8BIT-1:0] = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            control_zero_reg <= 8'h0;
            power_reg        <= '0;
            freeze_reg       <= 2'h0;
            timing_reg       <= timing_t'(`TIMING_RESET);
            start_reg        <= '0;
            state_reg        <= ST_IDLE;
            seq_flag_reg     <= 1'b0;
            ccf_reg          <= 8'h0;
            stat_read_reg    <= 1'b0;
            conv_idx_reg     <= 3'h0;
            period_reg       <= 6'h0;
            pre_cnt_reg      <= 5'h0;
            half_reg         <= 1'b0;
            prdata_reg       <= 32'h0;
            pready_reg       <= 1'b0;
            pslverr_reg      <= 1'b0;
            channel_reg      <= 4'h0;
            sample_reg       <= 1'b0;
            load_reg         <= 1'b0;
            irq_reg          <= 1'b0;
        end else begin
            control_zero_reg <= control_zero_next;
            power_reg        <= power_next;
            freeze_reg       <= freeze_next;
            timing_reg       <= timing_next;
            start_reg        <= start_next;
            state_reg        <= state_next;
            seq_flag_reg     <= seq_flag_next;
            ccf_reg          <= ccf_next;
            stat_read_reg    <= stat_read_next;
            conv_idx_reg     <= conv_idx_next;
            period_reg       <= period_next;
            pre_cnt_reg      <= pre_cnt_next;
            half_reg         <= half_next;
            prdata_reg       <= prdata_next;
            pready_reg       <= pready_next;
            pslverr_reg      <= pslverr_next;
            channel_reg      <= channel_next;
            sample_reg       <= sample_next;
            load_reg         <= load_next;
            irq_reg          <= irq_next;
        end
    end

    // A result is stored at the edge that ends its conversion unless a write aborts it.
    for (genvar i = 0; i < 8; i++) begin : g_result
        always_ff @(posedge MCLK) begin
            if (RESET) begin
                result_reg[i] <= '0;
            end else if (conv_end && conv_idx_reg == 3'(i) && !start && !abort) begin
                result_reg[i] <= load_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign PRDATA      = prdata_reg;
    assign PREADY      = pready_reg;
    assign PSLVERR     = pslverr_reg;
    assign ADC_CLK     = half_reg;
    assign ADC_POWER   = power_reg.converter_power_up;
    assign ADC_SAMPLE  = sample_reg;
    assign ADC_LOAD    = load_reg;
    assign ADC_TEN_BIT = timing_reg.ten_bit_select;
    assign ADC_CHANNEL = channel_reg;
    assign IRQ         = irq_reg;

endmodule // adc_sequence_control

//--- verification/adc_core_model.sv
// Analog core model: returns a code tied to the selected channel.
// Assumes ADC_POWER and ADC_CHANNEL come from the sequence control.
module adc_core_model (
    input  wire logic       MCLK,        // Clock.
    input  wire logic       ADC_POWER,   // Powered.
    input  wire logic [3:0] ADC_CHANNEL, // Channel.
    output logic      [9:0] ADC_DATA     // Code.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] junk = 10'h155;
    always @(posedge MCLK) junk <= ~junk;
    // A powered-down core gives a toggling pattern, never a stale code.
    assign ADC_DATA = ADC_POWER ? {ADC_CHANNEL, 6'h2d} : junk;
endmodule // adc_core_model

//--- verification/adc_seq_props.sv
// Assertions on the ports of the converter sequence control.
// Assumes binding to the design; APB writes land at the access edge.
`include "adc_seq_defs.svh"
module adc_seq_props (
    input wire logic        MCLK,         // Clock.
    input wire logic        RESET,        // Reset.
    input wire logic        PSEL,         // Select.
    input wire logic        PENABLE,      // Access.
    input wire logic        PWRITE,       // Write.
    input wire logic [7:0]  PADDR,        // Address.
    input wire logic [31:0] PWDATA,       // Write data.
    input wire logic [31:0] PRDATA,       // Read data.
    input wire logic        PREADY,       // Ready.
    input wire logic        SPECIAL_MODE, // Special.
    input wire logic        WAIT_MODE,    // Wait.
    input wire logic        DEBUG_ACTIVE, // Debug.
    input wire logic        ADC_POWER,    // Power.
    input wire logic        ADC_SAMPLE,   // Sample.
    input wire logic        ADC_LOAD,     // Load.
    input wire logic        ADC_TEN_BIT,  // Resolution.
    input wire logic        IRQ           // Interrupt.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wr;
    logic [2:0] cfg_reg, cfg_next;
    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    // Shadow of the wait-stop and freeze bits, taken from the bus writes.
    always_comb cfg_next = !wr ? cfg_reg : PADDR == `OFS_DEBUG_FREEZE ? {cfg_reg[2], PWDATA[1:0]}
        : PADDR == `OFS_POWER_IRQ ? {PWDATA[5], cfg_reg[1:0]} : cfg_reg;
    always_ff @(posedge MCLK) cfg_reg <= RESET ? 3'h0 : cfg_next;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    reserved_read_a : assert property (
        PSEL && !PENABLE && !PWRITE && PADDR == `OFS_RESERVED_CTRL && !SPECIAL_MODE
        |=> PRDATA == 32'h0) else $error("reserved read not zero");
    power_follows_a : assert property (wr && PADDR == `OFS_POWER_IRQ
        |=> ##1 ADC_POWER == $past(PWDATA[7], 2)) else $error("power bit not applied");
    ten_bit_a : assert property (wr && PADDR == `OFS_TIMING
        |=> ##1 ADC_TEN_BIT == $past(PWDATA[7], 2)) else $error("resolution not applied");
    unpowered_quiet_a : assert property (!ADC_POWER [*3]
        |-> !ADC_LOAD && !ADC_SAMPLE) else $error("activity while unpowered");
    abort_halts_a : assert property (wr && PADDR inside {`OFS_CONTROL_ZERO,
        `OFS_POWER_IRQ, `OFS_DEBUG_FREEZE, `OFS_TIMING} |=> ##1 (!ADC_LOAD && !ADC_SAMPLE) [*6])
        else $error("activity after abort");
    irq_drop_a : assert property (wr && PADDR == `OFS_START |=> ##1 !IRQ)
        else $error("interrupt kept after start");
    freeze_now_a : assert property ((DEBUG_ACTIVE && cfg_reg[1:0] == `FREEZE_NOW) [*3]
        |-> !ADC_LOAD) else $error("result loaded while frozen");
    wait_stop_a : assert property ((WAIT_MODE && cfg_reg[2]) [*3] |-> !ADC_LOAD)
        else $error("result loaded in wait mode");
    sample_ends_a : assert property ($rose(ADC_LOAD) |-> $past(!ADC_SAMPLE))
        else $error("sample phase overlaps result load");
    cover property ($rose(IRQ));
    cover property (ADC_LOAD && ADC_TEN_BIT);
    cover property ($fell(ADC_POWER));
endmodule // adc_seq_props
bind adc_sequence_control adc_seq_props u_adc_seq_props (.*);

//--- verification/tb_top.sv
// Self-checking bench of the converter sequence control.
// Assumes the core model and the bound checker are compiled first.
`include "adc_seq_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_seq_pkg::*;
    logic        mclk, reset, psel, penable, pwrite, special, waitm, debug, err;
    logic        pready, pslverr, aclk, apow, asmp, aload, aten, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  achan;
    logic [9:0]  adata;
    logic [7:0]  tv;
    logic        aclk_q;
    int          half_t = 0, edge_t = 0;
    start_t      st;
    int          n_errors = 0, checked = 0, loads = 0, base, cyc = 0, last = 0, gap;
    logic [7:0]  aborts [4] = '{`OFS_CONTROL_ZERO, `OFS_DEBUG_FREEZE, `OFS_TIMING, `OFS_POWER_IRQ};
    adc_sequence_control u_adc_sequence_control (.MCLK(mclk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SPECIAL_MODE(special), .WAIT_MODE(waitm),
        .DEBUG_ACTIVE(debug), .ADC_DATA(adata), .ADC_CLK(aclk), .ADC_POWER(apow),
        .ADC_SAMPLE(asmp), .ADC_LOAD(aload), .ADC_TEN_BIT(aten), .ADC_CHANNEL(achan), .IRQ(irq));
    adc_core_model u_adc_core_model (.MCLK(mclk), .ADC_POWER(apow), .ADC_CHANNEL(achan),
        .ADC_DATA(adata));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Counts result loads, the spacing of the last two and the converter clock half period.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (aload === 1'b1) begin
            loads <= loads + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        aclk_q <= aclk;
        if (aclk !== aclk_q) begin
            half_t <= cyc - edge_t;
            edge_t <= cyc;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int conv_len(input logic [7:0] t);
        int p;
        p = (t[4:0] == 5'h0) ? 1 : int'(t[4:0]);
        return ((2 << t[6:5]) + (t[7] ? 18 : 16)) * 2 * (p + 1);
    endfunction
    function automatic logic [31:0] exp_res(input start_t s, input logic ten, input logic [2:0] i);
        logic [3:0] c;
        c = s.eight_conversion_select ? {s.channel[3], i} : {s.channel[3:2], i[1:0]};
        c = s.multichannel_select ? c : s.channel;
        return {22'h0, c, ten ? 6'h2d : 6'h2c};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic run(input logic [7:0] pw, input logic [1:0] fz, input logic [7:0] tm,
                       input start_t s);
        apb(1'b1, `OFS_POWER_IRQ, {24'h0, pw});
        apb(1'b1, `OFS_DEBUG_FREEZE, {30'h0, fz});
        apb(1'b1, `OFS_TIMING, {24'h0, tm});
        repeat (8) @(posedge mclk);
        base = loads;
        apb(1'b1, `OFS_START, {24'h0, s});
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge mclk);
        repeat (2) @(posedge mclk);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1500000;
        n_errors++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, special, waitm, debug} = '0;
        reset = 1'b1;
        seed = 32'h050d1620;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        apb(1'b0, `OFS_TIMING, 0);
        chk(rd, 32'h01);
        apb(1'b1, 8'h40, 32'hff);
        chk(32'(err), 32'h1);
        apb(1'b1, `OFS_CONTROL_ZERO, 32'h5a);
        apb(1'b1, `OFS_RESERVED_CTRL, 32'ha5);
        apb(1'b0, `OFS_RESERVED_CTRL, 0);
        chk(rd, 32'h0);
        special <= 1'b1;
        apb(1'b0, `OFS_RESERVED_CTRL, 0);
        chk(rd, 32'h5a);
        apb(1'b1, `OFS_POWER_IRQ, 32'hff);
        apb(1'b0, `OFS_POWER_IRQ, 0);
        chk(rd, 32'he2);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            st = start_t'({1'b0, k[0], k[1], k[0] ^ k[1], seed[7:4]});
            tv = {seed[2] ^ k[0], seed[1:0] ^ k[1:0] ^ 2'h2, 3'h0, seed[9:8]};
            {waitm, debug} <= {k == 2, k == 3};
            run(8'h82, 2'h0, tv, st);
            wait_irq();
            chk(32'(loads - base), k[0] ? 32'h8 : 32'h4);
            chk(32'(gap), 32'(conv_len(tv)));
            chk(32'(half_t), (tv[4:0] == 5'h0) ? 32'h2 : 32'(tv[4:0]) + 32'h1);
            apb(1'b0, `OFS_STATUS, 0);
            chk({rd[15], rd[7:0]}, {1'b1, k[0] ? 8'hff : 8'h0f});
            apb(1'b0, {`OFS_RESULT_BASE, 5'h0}, 0);
            chk(rd, exp_res(st, tv[7], 3'h0));
            apb(1'b0, 8'h24, 0);
            chk(rd, exp_res(st, tv[7], 3'h1));
            apb(1'b0, `OFS_STATUS, 0);
            chk({rd[15], rd[1:0]}, 3'b110);
            base = loads;
            repeat (9 * gap) @(posedge mclk);
            chk(32'(loads != base), 32'(k[1]));
        end
        {waitm, debug} <= 2'b00;
        st = start_t'(8'h05);
        run(8'hc2, 2'h0, 8'h01, st);
        wait_irq();
        apb(1'b0, 8'h28, 0);
        apb(1'b1, 8'h2c, 0);
        apb(1'b0, `OFS_STATUS, 0);
        chk({rd[15], rd[3:0], irq}, 6'b000110);
        foreach (aborts[i]) begin
            run(8'h82, 2'h0, 8'h03, st);
            repeat (100) @(posedge mclk);
            apb(1'b1, aborts[i], 0);
            base = loads;
            repeat (1500) @(posedge mclk);
            chk(32'(loads - base), 32'h0);
        end
        for (int j = 0; j < 2; j++) begin
            {waitm, debug} <= j ? 2'b01 : 2'b10;
            run(j ? 8'h82 : 8'ha2, j ? `FREEZE_NOW : 2'h0, 8'h01, st);
            repeat (1500) @(posedge mclk);
            chk(32'(loads - base), 32'h0);
            {waitm, debug} <= 2'b00;
            wait_irq();
            chk(32'(loads - base), 32'h4);
        end
        run(8'h82, `FREEZE_FINISH, 8'h03, st);
        repeat (100) @(posedge mclk);
        debug <= 1'b1;
        repeat (1500) @(posedge mclk);
        chk(32'(loads - base), 32'h1);
        debug <= 1'b0;
        wait_irq();
        chk(32'(loads - base), 32'h4);
        conclude();
    end
endmodule // tb_top
